// [rtl/ape_top.sv]
// APB register bank driving audio path power enables and record gating
`timescale 1ns/1ps
module ape_top (
  input  wire logic                          clk_sys_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          ce_in,
  // APB slave
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [ape_pkg::ADDR_W-1:0]    paddr_in,
  input  wire logic [ape_pkg::DATA_W-1:0]    pwdata_in,
  input  wire logic [3:0]                    pstrb_in,
  output logic      [ape_pkg::DATA_W-1:0]    prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  // Speaker output enables from the speaker driver control, asynchronous
  input  wire logic                          right_speaker_output_en_in,
  input  wire logic                          left_speaker_output_en_in,
  // Record samples headed for the audio ports, same clock
  input  wire logic [ape_pkg::SAMPLE_W-1:0]  second_port_rec_left_data_in,
  input  wire logic                          second_port_rec_left_valid_in,
  input  wire logic                          third_port_sel_in,
  input  wire logic [ape_pkg::SAMPLE_W-1:0]  second_port_rec_right_data_in,
  input  wire logic                          second_port_rec_right_valid_in,
  // Line output power
  output logic                               line_out_a_neg_en_out,
  output logic                               line_out_a_neg_mixer_en_out,
  output logic                               line_out_a_pos_en_out,
  output logic                               line_out_a_pos_mixer_en_out,
  output logic                               line_out_b_neg_en_out,
  output logic                               line_out_b_neg_mixer_en_out,
  output logic                               line_out_b_pos_en_out,
  output logic                               line_out_b_pos_mixer_en_out,
  // Speaker stage power
  output logic                               right_speaker_mixer_en_out,
  output logic                               right_speaker_volume_amp_en_out,
  output logic                               left_speaker_mixer_en_out,
  output logic                               left_speaker_volume_amp_en_out,
  // Output mixer power
  output logic                               left_out_mixer_volume_en_out,
  output logic                               right_out_mixer_volume_en_out,
  output logic                               left_out_mixer_en_out,
  output logic                               right_out_mixer_en_out,
  // Record path, microphone and converter power
  output logic                               second_port_rec_left_en_out,
  output logic                               second_port_rec_right_en_out,
  output logic                               first_port_rec_left_en_out,
  output logic                               first_port_rec_right_en_out,
  output logic                               digital_mic_left_en_out,
  output logic                               digital_mic_right_en_out,
  output logic                               left_converter_en_out,
  // Gated record samples to the ports
  output logic      [ape_pkg::SAMPLE_W-1:0]  second_audio_port_left_data_out,
  output logic                               second_audio_port_left_valid_out,
  output logic      [ape_pkg::SAMPLE_W-1:0]  third_audio_port_left_data_out,
  output logic                               third_audio_port_left_valid_out,
  output logic      [ape_pkg::SAMPLE_W-1:0]  second_audio_port_right_data_out,
  output logic                               second_audio_port_right_valid_out
);

  // ========================================================================
  // Byte addresses of the registers
  localparam logic [ape_pkg::ADDR_W-1:0] OUT_STAGE_ADDR = {ape_pkg::OUT_STAGE_IDX, 2'b00};
  localparam logic [ape_pkg::ADDR_W-1:0] REC_PATH_ADDR  = {ape_pkg::REC_PATH_IDX, 2'b00};
  localparam logic [ape_pkg::ADDR_W-1:0] STATUS_ADDR    = {ape_pkg::STATUS_IDX, 2'b00};

  // ========================================================================
  // Declarations
  logic                          pready_q;
  logic                          pslverr_d;
  logic [ape_pkg::DATA_W-1:0]    prdata_d;
  logic                          access_start;
  logic                          access_done;
  logic                          hit_out_stage;
  logic                          hit_rec_path;
  logic                          hit_status;
  logic                          hit_any;
  logic                          bad_write;
  logic                          wr_out_stage;
  logic                          wr_rec_path;
  logic [ape_pkg::REG_W-1:0]     out_stage_q;
  logic [ape_pkg::REG_W-1:0]     rec_path_q;
  logic [ape_pkg::REG_W-1:0]     status_d;
  logic [1:0]                    spk_out_sync;
  logic                          spk_r_out_en;
  logic                          spk_l_out_en;
  logic                          spk_r_stage_d;
  logic                          spk_l_stage_d;
  logic [ape_pkg::REG_W-1:0]     out_pwr_d;
  logic [ape_pkg::REG_W-1:0]     out_pwr_q;
  logic [ape_pkg::REG_W-1:0]     rec_pwr_q;
  logic                          p2_left_on;
  logic                          p2_right_on;
  logic                          p2_left_to_second;
  logic                          p2_left_to_third;
  logic [ape_pkg::SAMPLE_W-1:0]  sec_l_data_d;
  logic                          sec_l_valid_d;
  logic [ape_pkg::SAMPLE_W-1:0]  thr_l_data_d;
  logic                          thr_l_valid_d;
  logic [ape_pkg::SAMPLE_W-1:0]  sec_r_data_d;
  logic                          sec_r_valid_d;

  // ========================================================================
  // APB phase detection; one wait state so every answer leaves a flop
  assign access_start = psel_in && penable_in && !pready_q;
  assign access_done  = psel_in && penable_in && pready_q;

  // Address decode; low address bits must be zero for a hit
  assign hit_out_stage = (paddr_in == OUT_STAGE_ADDR);
  assign hit_rec_path  = (paddr_in == REC_PATH_ADDR);
  assign hit_status    = (paddr_in == STATUS_ADDR);
  assign hit_any       = hit_out_stage || hit_rec_path || hit_status;

  // Status is read only, so a write to it is answered with an error
  assign bad_write = pwrite_in && hit_status;
  assign pslverr_d = !hit_any || bad_write;

  // Writes land only at the edge where pready is seen high
  assign wr_out_stage = access_done && pwrite_in && hit_out_stage;
  assign wr_rec_path  = access_done && pwrite_in && hit_rec_path;

  // ========================================================================
  // Read data mux; bits above the 16-bit registers read as zero
  assign status_d = {12'h000, spk_r_out_en, spk_l_out_en,
                     out_pwr_q[ape_pkg::SPK_R_BIT], out_pwr_q[ape_pkg::SPK_L_BIT]};
  assign prdata_d = (pwrite_in)     ? ape_pkg::RDATA_RST :
                    (hit_out_stage) ? {16'h0000, out_stage_q} :
                    (hit_rec_path)  ? {16'h0000, rec_path_q} :
                    (hit_status)    ? {16'h0000, status_d} :
                                      ape_pkg::RDATA_RST;

  // ========================================================================
  // APB response flops; pready pulses for one cycle per transfer
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pready_q    <= 1'b0;
      prdata_out  <= ape_pkg::RDATA_RST;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      pready_q    <= access_start;
      prdata_out  <= access_start ? prdata_d : ape_pkg::RDATA_RST;
      pslverr_out <= access_start && pslverr_d;
    end
  end

  assign pready_out = pready_q;

  // ========================================================================
  // The two software registers
  ape_en_reg #(
    .MASK (ape_pkg::OUT_STAGE_MASK),
    .RST  (ape_pkg::OUT_STAGE_RST)
  ) u_out_stage (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .wr_in      (wr_out_stage),
    .strb_in    (pstrb_in[1:0]),
    .wdata_in   (pwdata_in[15:0]),
    .q_out      (out_stage_q)
  );

  ape_en_reg #(
    .MASK (ape_pkg::REC_PATH_MASK),
    .RST  (ape_pkg::REC_PATH_RST)
  ) u_rec_path (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .wr_in      (wr_rec_path),
    .strb_in    (pstrb_in[1:0]),
    .wdata_in   (pwdata_in[15:0]),
    .q_out      (rec_path_q)
  );

  // ========================================================================
  // Speaker output enables come from a sequencer off this clock
  ape_sync2 #(
    .W (2)
  ) u_spk_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   ({right_speaker_output_en_in, left_speaker_output_en_in}),
    .sync_out   (spk_out_sync)
  );

  assign spk_r_out_en = spk_out_sync[1];
  assign spk_l_out_en = spk_out_sync[0];

  // Speaker stages run when software asks or when the speaker output is on
  assign spk_r_stage_d = out_stage_q[ape_pkg::SPK_R_BIT] || spk_r_out_en;
  assign spk_l_stage_d = out_stage_q[ape_pkg::SPK_L_BIT] || spk_l_out_en;

  // Effective output stage power, register value with speaker overrides
  always_comb begin
    out_pwr_d                     = out_stage_q;
    out_pwr_d[ape_pkg::SPK_R_BIT] = spk_r_stage_d;
    out_pwr_d[ape_pkg::SPK_L_BIT] = spk_l_stage_d;
  end

  // ========================================================================
  // Power enable flops; one cycle behind the register, so outputs are glitch free
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      out_pwr_q <= ape_pkg::OUT_STAGE_RST;
      rec_pwr_q <= ape_pkg::REC_PATH_RST;
    end else if (ce_in) begin
      out_pwr_q <= out_pwr_d;
      rec_pwr_q <= rec_path_q;
    end
  end

  // ========================================================================
  // Line outputs; driver and its mixer share one enable
  assign line_out_a_neg_en_out       = out_pwr_q[ape_pkg::LO_A_NEG_BIT];
  assign line_out_a_neg_mixer_en_out = out_pwr_q[ape_pkg::LO_A_NEG_BIT];
  assign line_out_a_pos_en_out       = out_pwr_q[ape_pkg::LO_A_POS_BIT];
  assign line_out_a_pos_mixer_en_out = out_pwr_q[ape_pkg::LO_A_POS_BIT];
  assign line_out_b_neg_en_out       = out_pwr_q[ape_pkg::LO_B_NEG_BIT];
  assign line_out_b_neg_mixer_en_out = out_pwr_q[ape_pkg::LO_B_NEG_BIT];
  assign line_out_b_pos_en_out       = out_pwr_q[ape_pkg::LO_B_POS_BIT];
  assign line_out_b_pos_mixer_en_out = out_pwr_q[ape_pkg::LO_B_POS_BIT];

  // Speaker mixer and volume amplifier share one effective enable
  assign right_speaker_mixer_en_out      = out_pwr_q[ape_pkg::SPK_R_BIT];
  assign right_speaker_volume_amp_en_out = out_pwr_q[ape_pkg::SPK_R_BIT];
  assign left_speaker_mixer_en_out       = out_pwr_q[ape_pkg::SPK_L_BIT];
  assign left_speaker_volume_amp_en_out  = out_pwr_q[ape_pkg::SPK_L_BIT];

  // Output mixers and their volume controls
  assign left_out_mixer_volume_en_out  = out_pwr_q[ape_pkg::MIX_L_VOL_BIT];
  assign right_out_mixer_volume_en_out = out_pwr_q[ape_pkg::MIX_R_VOL_BIT];
  assign left_out_mixer_en_out         = out_pwr_q[ape_pkg::MIX_L_BIT];
  assign right_out_mixer_en_out        = out_pwr_q[ape_pkg::MIX_R_BIT];

  // Record paths, microphone channels and left converter
  assign second_port_rec_left_en_out  = rec_pwr_q[ape_pkg::P2_REC_L_BIT];
  assign second_port_rec_right_en_out = rec_pwr_q[ape_pkg::P2_REC_R_BIT];
  assign first_port_rec_left_en_out   = rec_pwr_q[ape_pkg::P1_REC_L_BIT];
  assign first_port_rec_right_en_out  = rec_pwr_q[ape_pkg::P1_REC_R_BIT];
  assign digital_mic_left_en_out      = rec_pwr_q[ape_pkg::DMIC_L_BIT];
  assign digital_mic_right_en_out     = rec_pwr_q[ape_pkg::DMIC_R_BIT];
  assign left_converter_en_out        = rec_pwr_q[ape_pkg::CONV_L_BIT];

  // ========================================================================
  // Record sample gating; gated by the delayed enable so data never
  // leaves before the path it rides on is powered
  assign p2_left_on        = rec_pwr_q[ape_pkg::P2_REC_L_BIT];
  assign p2_right_on       = rec_pwr_q[ape_pkg::P2_REC_R_BIT];
  assign p2_left_to_second = p2_left_on && !third_port_sel_in;
  assign p2_left_to_third  = p2_left_on && third_port_sel_in;

  // Disabled paths send zero samples with valid low
  assign sec_l_data_d  = p2_left_to_second ? second_port_rec_left_data_in : ape_pkg::SAMPLE_RST;
  assign sec_l_valid_d = p2_left_to_second && second_port_rec_left_valid_in;
  assign thr_l_data_d  = p2_left_to_third ? second_port_rec_left_data_in : ape_pkg::SAMPLE_RST;
  assign thr_l_valid_d = p2_left_to_third && second_port_rec_left_valid_in;
  assign sec_r_data_d  = p2_right_on ? second_port_rec_right_data_in : ape_pkg::SAMPLE_RST;
  assign sec_r_valid_d = p2_right_on && second_port_rec_right_valid_in;

  // Sample output flops
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      second_audio_port_left_data_out   <= ape_pkg::SAMPLE_RST;
      second_audio_port_left_valid_out  <= 1'b0;
      third_audio_port_left_data_out    <= ape_pkg::SAMPLE_RST;
      third_audio_port_left_valid_out   <= 1'b0;
      second_audio_port_right_data_out  <= ape_pkg::SAMPLE_RST;
      second_audio_port_right_valid_out <= 1'b0;
    end else if (ce_in) begin
      second_audio_port_left_data_out   <= sec_l_data_d;
      second_audio_port_left_valid_out  <= sec_l_valid_d;
      third_audio_port_left_data_out    <= thr_l_data_d;
      third_audio_port_left_valid_out   <= thr_l_valid_d;
      second_audio_port_right_data_out  <= sec_r_data_d;
      second_audio_port_right_valid_out <= sec_r_valid_d;
    end
  end

endmodule // ape_top

// [shared/ape_pkg.sv]
// Constants for the audio path power enable register bank
// ==========================================================================
package ape_pkg;

  // ========================================================================
  // Bus geometry and register indices (byte address is four times index)
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 16;
  localparam int          SAMPLE_W        = 16;
  localparam logic [9:0]  OUT_STAGE_IDX   = 10'h003;
  localparam logic [9:0]  REC_PATH_IDX    = 10'h004;
  localparam logic [9:0]  STATUS_IDX      = 10'h03F;

  // ========================================================================
  // Output stage register fields
  localparam int          LO_A_NEG_BIT    = 13;
  localparam int          LO_A_POS_BIT    = 12;
  localparam int          LO_B_NEG_BIT    = 11;
  localparam int          LO_B_POS_BIT    = 10;
  localparam int          SPK_R_BIT       = 9;
  localparam int          SPK_L_BIT       = 8;
  localparam int          MIX_L_VOL_BIT   = 7;
  localparam int          MIX_R_VOL_BIT   = 6;
  localparam int          MIX_L_BIT       = 5;
  localparam int          MIX_R_BIT       = 4;
  localparam logic [15:0] OUT_STAGE_MASK  = 16'h3FF0;
  localparam logic [15:0] OUT_STAGE_RST   = 16'h0000;

  // ========================================================================
  // Record path register fields
  localparam int          P2_REC_L_BIT    = 13;
  localparam int          P2_REC_R_BIT    = 12;
  localparam int          P1_REC_L_BIT    = 9;
  localparam int          P1_REC_R_BIT    = 8;
  localparam int          DMIC_L_BIT      = 3;
  localparam int          DMIC_R_BIT      = 2;
  localparam int          CONV_L_BIT      = 1;
  localparam logic [15:0] REC_PATH_MASK   = 16'h330E;
  localparam logic [15:0] REC_PATH_RST    = 16'h0000;

  // ========================================================================
  // Status register fields and reset values of the bus side
  localparam int          ST_SPK_L_BIT    = 0;
  localparam int          ST_SPK_R_BIT    = 1;
  localparam int          ST_SPKO_L_BIT   = 2;
  localparam int          ST_SPKO_R_BIT   = 3;
  localparam logic [31:0] RDATA_RST       = 32'h0000_0000;
  localparam logic [15:0] SAMPLE_RST      = 16'h0000;

endpackage

// [rtl/ape_sync2.sv]
// Two-flop synchroniser for levels arriving from another domain
`timescale 1ns/1ps
module ape_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic         sys_rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ========================================================================
  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // ape_sync2

// [rtl/ape_en_reg.sv]
// One 16-bit enable register with byte strobes and a writable mask
`timescale 1ns/1ps
module ape_en_reg #(
  parameter logic [15:0] MASK = 16'hFFFF,
  parameter logic [15:0] RST  = 16'h0000
) (
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        ce_in,
  input  wire logic        wr_in,
  input  wire logic [1:0]  strb_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] q_out
);

  logic [15:0] lane_mask;
  logic [15:0] keep_mask;
  logic [15:0] q_d;

  // ========================================================================
  // Only assigned bits in strobed lanes take the new value
  assign lane_mask = {{8{strb_in[1]}}, {8{strb_in[0]}}} & MASK;
  assign keep_mask = ~lane_mask & MASK;
  assign q_d       = (wdata_in & lane_mask) | (q_out & keep_mask);

  // Reset clears every enable; unassigned bits never leave zero
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      q_out <= RST;
    end else if (ce_in && wr_in) begin
      q_out <= q_d;
    end
  end

endmodule // ape_en_reg

// [tb/ape_checker.sv]
// Assertions on the audio path power enable bank
`timescale 1ns/1ps
module ape_checker (
  input wire logic        clk_sys_in, sys_rst_in, ce_in, psel_in, penable_in,
  input wire logic        pwrite_in, pready_out, pslverr_out, third_port_sel_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in, prdata_out,
  input wire logic [3:0]  pstrb_in,
  input wire logic        right_speaker_output_en_in, left_speaker_output_en_in,
  input wire logic        second_port_rec_left_valid_in, second_port_rec_right_valid_in,
  input wire logic        line_out_a_neg_en_out, line_out_a_neg_mixer_en_out,
  input wire logic        line_out_b_pos_en_out, line_out_b_pos_mixer_en_out,
  input wire logic        right_speaker_mixer_en_out, left_speaker_mixer_en_out,
  input wire logic        right_speaker_volume_amp_en_out, left_speaker_volume_amp_en_out,
  input wire logic        second_port_rec_left_en_out, second_port_rec_right_en_out,
  input wire logic        second_audio_port_left_valid_out, third_audio_port_left_valid_out,
  input wire logic        second_audio_port_right_valid_out
);
  // ==========================================================================
  // A frozen clock enable stalls every flop, so timing relations pause too
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in || !ce_in);
  wire wr_out = pready_out && psel_in && penable_in && pwrite_in && paddr_in == 12'h00C;
  wire rec_l_on = second_port_rec_left_valid_in && second_port_rec_left_en_out;
  // ==========================================================================
  // Power outputs follow a landed write two edges later
  property p_lo_a; wr_out && pstrb_in[1] |=> ##1 {line_out_a_neg_en_out,
    line_out_a_neg_mixer_en_out} == {2{$past(pwdata_in[13], 2)}}; endproperty
  a_lo_a: assert property (p_lo_a) else $error("line out A negative power wrong");
  property p_lo_b; wr_out && pstrb_in[1] |=> ##1 {line_out_b_pos_en_out,
    line_out_b_pos_mixer_en_out} == {2{$past(pwdata_in[10], 2)}}; endproperty
  a_lo_b: assert property (p_lo_b) else $error("line out B positive power wrong");
  property p_spk_bit; wr_out && pstrb_in[1] && pwdata_in[8] |=> ##1
    left_speaker_mixer_en_out && left_speaker_volume_amp_en_out; endproperty
  a_spk_bit: assert property (p_spk_bit) else $error("left speaker stage not powered");
  // Speaker output enables pass two sync flops and one output flop
  property p_spk_r; right_speaker_output_en_in [*4] |->
    right_speaker_mixer_en_out && right_speaker_volume_amp_en_out; endproperty
  a_spk_r: assert property (p_spk_r) else $error("right speaker override missing");
  property p_spk_l; left_speaker_output_en_in [*4] |->
    left_speaker_mixer_en_out && left_speaker_volume_amp_en_out; endproperty
  a_spk_l: assert property (p_spk_l) else $error("left speaker override missing");
  // Record samples pass only while their path is on
  property p_rec_l; second_audio_port_left_valid_out == $past(rec_l_on && !third_port_sel_in)
    && third_audio_port_left_valid_out == $past(rec_l_on && third_port_sel_in); endproperty
  a_rec_l: assert property (p_rec_l) else $error("left record gating wrong");
  property p_rec_r; second_audio_port_right_valid_out ==
    $past(second_port_rec_right_valid_in && second_port_rec_right_en_out); endproperty
  a_rec_r: assert property (p_rec_r) else $error("right record gating wrong");
  // Unmapped places refuse and unassigned record path bits read zero
  property p_err; pready_out && !(paddr_in inside {12'h00C, 12'h010})
    && !(paddr_in == 12'h0FC && !pwrite_in) |-> pslverr_out; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_rdz; pready_out && !pwrite_in && paddr_in == 12'h010 |->
    (prdata_out & ~{16'h0000, ape_pkg::REC_PATH_MASK}) == 32'h0000_0000; endproperty
  a_rdz: assert property (p_rdz) else $error("unassigned record bits read nonzero");
  c_wr: cover property (wr_out);
  c_err: cover property (pready_out && pslverr_out);
  c_rec: cover property (second_audio_port_left_valid_out);
endmodule // ape_checker

bind ape_top ape_checker u_ape_checker (.*);

// [tb/ape_tb_top.sv]
// Self-checking bench for the audio path power enable register bank
`timescale 1ns/1ps
module ape_tb_top;
  // ==========================================================================
  // Design ports
  logic clk_sys_in, sys_rst_in, ce_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0] pstrb_in;
  logic right_speaker_output_en_in, left_speaker_output_en_in, third_port_sel_in, er;
  logic second_port_rec_left_valid_in, second_port_rec_right_valid_in;
  logic [15:0] second_port_rec_left_data_in, second_port_rec_right_data_in;
  logic [15:0] second_audio_port_left_data_out, third_audio_port_left_data_out;
  logic [15:0] second_audio_port_right_data_out;
  logic second_audio_port_left_valid_out, third_audio_port_left_valid_out;
  logic second_audio_port_right_valid_out, line_out_a_neg_en_out, line_out_a_neg_mixer_en_out;
  logic line_out_a_pos_en_out, line_out_a_pos_mixer_en_out, line_out_b_neg_en_out;
  logic line_out_b_neg_mixer_en_out, line_out_b_pos_en_out, line_out_b_pos_mixer_en_out;
  logic right_speaker_mixer_en_out, right_speaker_volume_amp_en_out, left_speaker_mixer_en_out;
  logic left_speaker_volume_amp_en_out, left_out_mixer_volume_en_out, left_out_mixer_en_out;
  logic right_out_mixer_volume_en_out, right_out_mixer_en_out, second_port_rec_left_en_out;
  logic second_port_rec_right_en_out, first_port_rec_left_en_out, first_port_rec_right_en_out;
  logic digital_mic_left_en_out, digital_mic_right_en_out, left_converter_en_out;
  int fails, num_checks, cycles;
  // Power outputs gathered in register bit order, MSB first
  wire [15:0] out_v = {line_out_a_neg_en_out, line_out_a_neg_mixer_en_out, line_out_a_pos_en_out,
    line_out_a_pos_mixer_en_out, line_out_b_neg_en_out, line_out_b_neg_mixer_en_out,
    line_out_b_pos_en_out, line_out_b_pos_mixer_en_out, right_speaker_mixer_en_out,
    right_speaker_volume_amp_en_out, left_speaker_mixer_en_out, left_speaker_volume_amp_en_out,
    left_out_mixer_volume_en_out, right_out_mixer_volume_en_out, left_out_mixer_en_out,
    right_out_mixer_en_out};
  wire [6:0] rec_v = {second_port_rec_left_en_out, second_port_rec_right_en_out,
    first_port_rec_left_en_out, first_port_rec_right_en_out, digital_mic_left_en_out,
    digital_mic_right_en_out, left_converter_en_out};
  wire [2:0] vld_v = {second_audio_port_left_valid_out, third_audio_port_left_valid_out,
    second_audio_port_right_valid_out};
  ape_top u_ape_top (.*);
  // ==========================================================================
  // Clock; cycle ceiling so a hang still reaches the verdict
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    logic [15:0] v, m;
    logic [11:0] a;
    {sys_rst_in, ce_in, pstrb_in, psel_in, penable_in, pwrite_in} = {1'b1, 1'b1, 4'hF, 3'b000};
    {paddr_in, pwdata_in, third_port_sel_in} = '0;
    {right_speaker_output_en_in, left_speaker_output_en_in} = 2'b00;
    {second_port_rec_left_valid_in, second_port_rec_right_valid_in} = 2'b00;
    {second_port_rec_left_data_in, second_port_rec_right_data_in} = {16'hA5C3, 16'h3C5A};
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      apb(1'b0, r ? 12'h010 : 12'h00C, 32'h0);
      chk("reset_value", rd, 32'h0);
      for (int i = 0; i < 16; i++) begin
        a = r ? 12'h010 : 12'h00C;
        m = r ? 16'h330E : 16'h3FF0;
        v = 16'h0001 << i;
        apb(1'b1, a, {16'hFFFF, v});
        apb(1'b0, a, 32'h0);
        chk("readback", rd, {16'h0, v & m});
        if (r == 0) chk("out_power", out_v, {{2{v[13]}}, {2{v[12]}}, {2{v[11]}}, {2{v[10]}},
          {2{v[9]}}, {2{v[8]}}, v[7:4]});
        else chk("rec_power", rec_v, {v[13:12], v[9:8], v[3:1]});
      end
    end
    // Refused accesses leave the register untouched
    apb(1'b1, 12'h00C, 32'h3FF0);
    foreach (m[i]) if (i < 3) begin
      apb(1'b1, i == 0 ? 12'h014 : (i == 1 ? 12'h0FC : 12'h00D), 32'hFFFF);
      chk("refused", er, 1'b1);
    end
    apb(1'b0, 12'h00C, 32'h0);
    chk("kept", rd, 32'h3FF0);
    // Speaker output enables override clear register bits
    apb(1'b1, 12'h00C, 32'h0);
    right_speaker_output_en_in <= 1'b1;
    repeat (5) @(posedge clk_sys_in);
    chk("spk_right", out_v[7:4], 4'b1100);
    {right_speaker_output_en_in, left_speaker_output_en_in} <= 2'b01;
    repeat (5) @(posedge clk_sys_in);
    chk("spk_left", out_v[7:4], 4'b0011);
    left_speaker_output_en_in <= 1'b0;
    // Record samples gated until path enabled
    {second_port_rec_left_valid_in, second_port_rec_right_valid_in} <= 2'b11;
    repeat (3) @(posedge clk_sys_in);
    chk("gated", vld_v, 3'b000);
    apb(1'b1, 12'h010, 32'h3000);
    repeat (3) @(posedge clk_sys_in);
    chk("second_port", {vld_v, second_audio_port_left_data_out}, {3'b101, 16'hA5C3});
    chk("right_data", second_audio_port_right_data_out, 16'h3C5A);
    third_port_sel_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("third_port", {vld_v, third_audio_port_left_data_out}, {3'b011, 16'hA5C3});
    // Reset in mid-run clears every enable
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    apb(1'b0, 12'h010, 32'h0);
    chk("mid_reset", {rd[15:0], out_v}, 32'h0);
    chk("mid_reset_rec", rec_v, 32'h0);
    summarize();
  end
endmodule // ape_tb_top
